//--- rtl/sfm_master.sv
// Serial-peripheral frame master: framing, clocking and select generation
`timescale 1ns/10ps
module sfm_master
	import sfm_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic LINK_CLK_I,
	input wire sfm_cfg_s CFG_I,
	input wire logic [SFM_DATA_W-1:0] TX_DATA_I,
	input wire logic TX_VALID_I,
	output logic TX_READY_O,
	output logic [SFM_DATA_W-1:0] RX_DATA_O,
	output logic RX_VALID_O,
	output logic BUSY_O,
	output logic SCLK_O,
	output logic MOSI_O,
	input wire logic MISO_I,
	output logic [SFM_NUM_SEL-1:0] SEL_O,
	output logic [SFM_NUM_SEL-1:0] SEL_OE_B_O,
	input wire logic [SFM_NUM_SEL-1:0] SEL_I,
	output logic LINK_SEL_SEEN_O
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_b_r;
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_s1_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_b_r <= rst_s1_r;
		end
	end

	logic lrst_s1_r;
	logic lrst_b_r;
	always_ff @(posedge LINK_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lrst_s1_r <= 1'b0;
			lrst_b_r <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_b_r <= lrst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic miso_s1_r;
	logic miso_r;
	always_ff @(posedge REF_CLK_I or negedge rst_b_r) begin
		if (!rst_b_r) begin
			miso_s1_r <= 1'b0;
			miso_r <= 1'b0;
		end else begin
			miso_s1_r <= MISO_I;
			miso_r <= miso_s1_r;
		end
	end

	// Slave operation: select observed in the external master's clock domain
	logic [SFM_NUM_SEL-1:0] lsel_s1_r;
	logic [SFM_NUM_SEL-1:0] lsel_r;
	always_ff @(posedge LINK_CLK_I or negedge lrst_b_r) begin
		if (!lrst_b_r) begin
			lsel_s1_r <= '0;
			lsel_r <= '0;
		end else begin
			lsel_s1_r <= SEL_I;
			lsel_r <= lsel_s1_r;
		end
	end

	logic seen_s1_r;
	logic seen_r;
	always_ff @(posedge REF_CLK_I or negedge rst_b_r) begin
		if (!rst_b_r) begin
			seen_s1_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			seen_s1_r <= |(lsel_r ^ ~CFG_I.sel_active_high);
			seen_r <= seen_s1_r;
		end
	end
	assign LINK_SEL_SEEN_O = seen_r & ~CFG_I.master;

	// ----------------------------------------------------------------
	// Configuration decode
	// ----------------------------------------------------------------
	logic enabled;
	logic pulse_mode;
	logic eff_pol;
	logic eff_pha;
	logic [4:0] flen;
	logic [3:0] r_set;
	logic [5:0] qtr_cnt;
	logic [5:0] tq_cnt;
	always_comb begin
		enabled = CFG_I.master && CFG_I.block_mode == SFM_BLOCK_MODE_SERIAL;
		pulse_mode = CFG_I.variant == SFM_VARIANT_PULSE;
		eff_pol = CFG_I.polarity;
		eff_pha = CFG_I.phase;
		if (pulse_mode) begin
			eff_pol = 1'b0;
			eff_pha = 1'b1;
		end else if (CFG_I.variant == SFM_VARIANT_HALF) begin
			eff_pol = 1'b0;
			eff_pha = 1'b0;
		end
		flen = CFG_I.frame_len;
		if (flen < SFM_LEN_MIN) begin
			flen = SFM_LEN_MIN;
		end else if (flen > SFM_LEN_MAX) begin
			flen = SFM_LEN_MAX;
		end
		r_set = CFG_I.oversample_setting;
		// Truncating divisions by shift
		qtr_cnt = {4'h0, r_set[3:2]} + 6'h01;
		tq_cnt = {3'h0, r_set[3:1]} + 6'h01 + qtr_cnt;
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SFM_IDLE, SFM_LEAD, SFM_BITS, SFM_GAP
	} sfm_state_e;

	sfm_state_e state_r;
	logic [5:0] tick_r;
	logic [4:0] bit_r;
	logic [SFM_DATA_W-1:0] sh_tx_r;
	logic [SFM_DATA_W-1:0] sh_rx_r;
	logic sclk_r;
	logic mosi_r;
	logic sel_act_r;
	logic pulse_r;
	logic have_next;
	logic period_end;
	logic last_bit;

	assign have_next = TX_VALID_I && enabled;
	assign period_end = tick_r == {2'h0, r_set};
	assign last_bit = bit_r == flen - 5'h01;
	// Queue word taken only when a frame launches
	assign TX_READY_O = enabled && (state_r == SFM_IDLE
		|| (state_r == SFM_BITS && period_end && last_bit && !CFG_I.separated));
	assign BUSY_O = state_r != SFM_IDLE;

	function automatic logic pick_bit(input logic [SFM_DATA_W-1:0] w, input logic [4:0] i,
		input logic [4:0] n, input logic lsb);
		logic [4:0] idx;
		idx = lsb ? i : n - 5'h01 - i;
		pick_bit = w[idx[3:0]];
	endfunction

	always_ff @(posedge REF_CLK_I or negedge rst_b_r) begin
		if (!rst_b_r) begin
			state_r <= SFM_IDLE;
			tick_r <= '0;
			bit_r <= '0;
			sh_tx_r <= '0;
		end else begin
			tick_r <= (state_r == SFM_IDLE || period_end) ? 6'h00 : tick_r + 6'h01;
			case (state_r)
				SFM_IDLE: begin
					if (have_next) begin
						sh_tx_r <= TX_DATA_I;
						bit_r <= '0;
						state_r <= (pulse_mode && CFG_I.lead) ? SFM_LEAD : SFM_BITS;
					end
				end
				SFM_LEAD: begin
					if (period_end) begin
						state_r <= SFM_BITS;
					end
				end
				SFM_BITS: begin
					if (period_end) begin
						bit_r <= bit_r + 5'h01;
						if (last_bit) begin
							bit_r <= '0;
							if (CFG_I.separated) begin
								state_r <= SFM_GAP;
							end else if (have_next) begin
								sh_tx_r <= TX_DATA_I;
							end else begin
								state_r <= SFM_IDLE;
							end
						end
					end
				end
				SFM_GAP: begin
					if (period_end) begin
						state_r <= SFM_IDLE;
					end
				end
				default: state_r <= SFM_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin timing within each bit period
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge rst_b_r) begin
		if (!rst_b_r) begin
			sclk_r <= 1'b0;
			mosi_r <= 1'b0;
		end else begin
			if (state_r != SFM_BITS) begin
				sclk_r <= eff_pol;
			end else if (tick_r == qtr_cnt - 6'h01) begin
				sclk_r <= ~eff_pol; // leading edge
			end else if (tick_r == tq_cnt - 6'h01) begin
				sclk_r <= eff_pol; // trailing edge
			end
			// Phase 0: bit set up at period start, quarter period ahead of the edge
			if (state_r == SFM_BITS && tick_r == 6'h00) begin
				mosi_r <= pick_bit(sh_tx_r, bit_r, flen, CFG_I.lsb_first);
			end
		end
	end

	// MISO reaches miso_r two cycles late: phase 0 reads it two ticks after the
	// leading edge is launched, so the first bit presented with select is caught.
	// Limitation: oversample setting below 2 leaves no room for this tick.
	logic cap_now;
	assign cap_now = state_r == SFM_BITS
		&& tick_r == (eff_pha ? tq_cnt - 6'h01 : qtr_cnt + 6'h01);

	always_ff @(posedge REF_CLK_I or negedge rst_b_r) begin
		if (!rst_b_r) begin
			sh_rx_r <= '0;
			RX_DATA_O <= '0;
			RX_VALID_O <= 1'b0;
		end else begin
			RX_VALID_O <= 1'b0;
			if (cap_now) begin
				sh_rx_r[CFG_I.lsb_first ? bit_r[3:0] : 4'(flen - 5'h01 - bit_r)] <= miso_r;
			end
			if (state_r == SFM_BITS && period_end && last_bit) begin
				RX_DATA_O <= sh_rx_r;
				RX_VALID_O <= 1'b1;
			end
			if (state_r == SFM_IDLE && have_next) begin
				sh_rx_r <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Select generation
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge rst_b_r) begin
		if (!rst_b_r) begin
			sel_act_r <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			sel_act_r <= state_r == SFM_BITS || (state_r == SFM_IDLE && have_next);
			if (!pulse_mode || !enabled) begin
				pulse_r <= 1'b0;
			end else if (CFG_I.lead) begin
				// Pulse during lead period, or over last bit ahead of a follow-on frame
				pulse_r <= (state_r == SFM_IDLE && have_next)
					|| (state_r == SFM_LEAD && !period_end)
					|| (state_r == SFM_BITS && bit_r == flen - 5'h02 && period_end && have_next)
					|| (state_r == SFM_BITS && last_bit && !period_end && pulse_r);
			end else begin
				pulse_r <= (state_r == SFM_IDLE && have_next)
					|| (state_r == SFM_BITS && bit_r == 5'h00 && !period_end)
					|| (state_r == SFM_BITS && last_bit && period_end && have_next);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < SFM_NUM_SEL; g++) begin : g_sel
			logic act;
			assign act = pulse_mode ? pulse_r
				: (sel_act_r && CFG_I.sel_index == 2'(g));
			// Standard select honours its polarity; the frame pulse is always active high
			assign SEL_O[g] = pulse_mode ? act : act ~^ CFG_I.sel_active_high[g];
			assign SEL_OE_B_O[g] = ~CFG_I.master;
		end
	endgenerate

	assign SCLK_O = sclk_r;
	assign MOSI_O = mosi_r;

endmodule // sfm_master

//--- rtl/sfm_pkg.sv
// Package for the serial-peripheral frame master: constants and carrier types
// Overview of operation
// - Continuous: select asserts once data queued
// - Continuous: deselect when queue and shifter empty
// - Separated: one clock period deselect between frames
// - Frame length 4 to 16, default eight
// - Most or least significant bit first
// - Standard select low across frames, high idle
// - Clock idles at polarity value
// - Phase 0 leading capture, phase 1 trailing
// - Modes 0/3 drive falling; 1/2 drive rising; code sets MOSI at each bit-period start in every mode
// - Phase 0: first bit valid before edge
// - Clock period is oversample setting plus one
// - Three-quarter spacing ((R/2)+1)+((R/4)+1) cycles
// - Quarter spacing (R/4)+1, divisions truncated
// - Frame pulse: one-bit high start pulse
// - Lead select: pulse precedes or coincides
// - Preceding back-to-back: pulse on last bit
// - Frame pulse uses clock mode 1 only
// - Four selects, each with own polarity
package sfm_pkg;

	localparam logic [1:0] SFM_BLOCK_MODE_SERIAL = 2'h1;
	localparam logic [1:0] SFM_VARIANT_STANDARD = 2'h0;
	localparam logic [1:0] SFM_VARIANT_PULSE = 2'h1;
	localparam logic [1:0] SFM_VARIANT_HALF = 2'h2;
	localparam int SFM_CTRL_VARIANT_HI = 25;
	localparam int SFM_CTRL_VARIANT_LO = 24;
	localparam int SFM_CTRL_POLARITY_BIT = 3;
	localparam int SFM_CTRL_PHASE_BIT = 2;
	localparam int SFM_CTRL_LEAD_BIT = 1;
	localparam logic [4:0] SFM_LEN_MIN = 5'h04;
	localparam logic [4:0] SFM_LEN_MAX = 5'h10;
	localparam logic [4:0] SFM_LEN_RESET = 5'h08;
	localparam logic [3:0] SFM_OVS_RESET = 4'h5;
	localparam int SFM_NUM_SEL = 4;
	localparam int SFM_DATA_W = 16;

	typedef struct packed {
		logic [1:0] block_mode;
		logic [1:0] variant;
		logic polarity;
		logic phase;
		logic lead;
		logic separated;
		logic master;
		logic lsb_first;
		logic [4:0] frame_len;
		logic [3:0] oversample_setting;
		logic [1:0] sel_index;
		logic [SFM_NUM_SEL-1:0] sel_active_high;
	} sfm_cfg_s;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic [SFM_NUM_SEL-1:0] sel;
	} sfm_pins_s;

endpackage : sfm_pkg

//--- dv/sfm_master_asserts.sv
// Pin-level checker for the frame master
`timescale 1ns/10ps
module sfm_master_asserts
	import sfm_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire sfm_cfg_s CFG_I,
	input wire logic TX_VALID_I,
	input wire logic TX_READY_O,
	input wire logic BUSY_O,
	input wire logic SCLK_O,
	input wire logic MOSI_O,
	input wire logic [SFM_NUM_SEL-1:0] SEL_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_B_I);
	logic std, act, cap, pol;
	assign std = CFG_I.variant == SFM_VARIANT_STANDARD && CFG_I.master;
	assign act = SEL_O[0] == CFG_I.sel_active_high[0];
	assign pol = CFG_I.polarity;
	// Half duplex runs clock mode 0, so it captures on the rising edge
	assign cap = CFG_I.variant == SFM_VARIANT_HALF || (std && !(CFG_I.polarity ^ CFG_I.phase));
	// Spacing figures below assume oversample setting 5
	chk_sclk_idle: assert property (
		std && !BUSY_O && !$past(BUSY_O) && $past(pol) == pol |-> SCLK_O == pol)
		else $error("sclk idle level wrong");
	chk_sel_idle: assert property (
		std && !BUSY_O && !$past(BUSY_O) |-> !act)
		else $error("select active while idle");
	chk_take_sel: assert property (
		std && TX_VALID_I && TX_READY_O && !BUSY_O |=> act)
		else $error("select not asserted after take");
	chk_ready_refused: assert property (
		!CFG_I.master || CFG_I.block_mode != SFM_BLOCK_MODE_SERIAL |-> !TX_READY_O)
		else $error("word taken while not master");
	// Select to leading edge is the quarter spacing of 2 cycles
	chk_first_edge: assert property (
		std && $rose(act) |-> ##1 SCLK_O == pol ##1 SCLK_O != pol)
		else $error("first clock edge not at quarter spacing");
	chk_sclk_half: assert property (
		std && BUSY_O && $changed(SCLK_O) && SCLK_O != pol
		|-> (SCLK_O != pol)[*3] ##1 SCLK_O == pol)
		else $error("clock half wrong");
	chk_mosi_cap: assert property (
		BUSY_O && $changed(SCLK_O) && SCLK_O == cap |-> $stable(MOSI_O))
		else $error("data moved on capture edge");
	// The registered clock needs one edge to follow a variant switch
	chk_pulse_sclk: assert property (
		CFG_I.variant == SFM_VARIANT_PULSE && $past(CFG_I.variant) == SFM_VARIANT_PULSE
		&& !BUSY_O |-> !SCLK_O)
		else $error("pulse variant clock not low");
	chk_pulse_width: assert property (
		CFG_I.variant == SFM_VARIANT_PULSE && CFG_I.master && $rose(SEL_O[0])
		|-> SEL_O[0][*6] ##1 !SEL_O[0])
		else $error("start pulse not one bit period");
endmodule // sfm_master_asserts

bind sfm_master sfm_master_asserts i_chk (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
	.CFG_I(CFG_I), .TX_VALID_I(TX_VALID_I), .TX_READY_O(TX_READY_O), .BUSY_O(BUSY_O),
	.SCLK_O(SCLK_O), .MOSI_O(MOSI_O), .SEL_O(SEL_O));

//--- dv/sfm_slave_model.sv
// Behavioural slave at the far end of the link
`timescale 1ns/10ps
module sfm_slave_model (
	input wire logic sclk_i,
	input wire logic mosi_i,
	input wire logic sel_act_i,
	input wire logic cap_rise_i,
	input wire logic lsb_i,
	input wire logic [4:0] len_i,
	input wire logic [15:0] reply_i,
	output logic miso_o,
	output logic [15:0] got_o
);
	int n = 0;
	function automatic int bi(int k);
		return lsb_i ? k : int'(len_i) - 1 - k;
	endfunction
	initial begin
		miso_o = 1'b0;
		got_o = 16'h0000;
	end
	// Released line shows the inverse, never a stale bit
	always @(sel_act_i) begin
		n <= 0;
		miso_o <= sel_act_i ? reply_i[bi(0)] : ~miso_o;
	end
	always @(sclk_i) begin
		if (sel_act_i && sclk_i === cap_rise_i) begin
			got_o[bi(n)] <= mosi_i;
			n <= (n + 1 == int'(len_i)) ? 0 : n + 1;
		end else if (sel_act_i) begin
			miso_o <= reply_i[bi(n)];
		end
	end
endmodule // sfm_slave_model

//--- dv/sfm_master_tb_top.sv
// Self-checking bench for the frame master
`timescale 1ns/10ps
module sfm_master_tb_top
	import sfm_pkg::*;
;
	logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, link_en = 1'b1, valid = 1'b0;
	logic miso, ready, rxv, busy, sclk, mosi, seen, sel_act, cap;
	logic [15:0] data = 16'h0000, rx, got, reply = 16'h0000;
	logic [3:0] sel, oe_b, sel_in = 4'hf;
	sfm_cfg_s cfg = '0;
	int n_fail = 0, checks = 0, n_edge = 0, n_rxv = 0, cyc = 0;
	always #4 clk = ~clk;
	always #15 if (link_en) lclk = ~lclk;
	assign sel_act = cfg.variant == SFM_VARIANT_PULSE || sel[0] == cfg.sel_active_high[0];
	assign cap = cfg.variant == SFM_VARIANT_PULSE ? 1'b0
		: cfg.variant == SFM_VARIANT_HALF ? 1'b1 : !(cfg.polarity ^ cfg.phase);
	sfm_master i_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .LINK_CLK_I(lclk), .CFG_I(cfg),
		.TX_DATA_I(data), .TX_VALID_I(valid), .TX_READY_O(ready), .RX_DATA_O(rx),
		.RX_VALID_O(rxv), .BUSY_O(busy), .SCLK_O(sclk), .MOSI_O(mosi), .MISO_I(miso),
		.SEL_O(sel), .SEL_OE_B_O(oe_b), .SEL_I(sel_in), .LINK_SEL_SEEN_O(seen));
	sfm_slave_model i_slave (.sclk_i(sclk), .mosi_i(mosi), .sel_act_i(sel_act),
		.cap_rise_i(cap), .lsb_i(cfg.lsb_first), .len_i(cfg.frame_len),
		.reply_i(reply), .miso_o(miso), .got_o(got));
	always @(posedge sel[0]) n_edge++;
	always @(negedge clk) if (rxv === 1'b1) n_rxv++;
	task automatic chk(string what, logic [15:0] exp, logic [15:0] seen_v);
		checks++;
		if (exp !== seen_v) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen_v);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Two frames, back to back except in separated mode, then select edges and data compared
	task automatic run(logic [15:0] a, logic [15:0] b, logic [15:0] ee, logic dchk);
		logic [15:0] m;
		int e0, r0, t;
		m = 16'hffff >> (16 - cfg.frame_len);
		e0 = n_edge;
		r0 = n_rxv;
		reply = ~b;
		for (int k = 0; k < 2; k++) begin
			t = 0;
			@(negedge clk);
			data = k ? b : a;
			valid = 1'b1;
			while (ready !== 1'b1 && t < 300) begin
				@(negedge clk);
				t++;
			end
			@(posedge clk);
		end
		@(negedge clk);
		valid = 1'b0;
		t = 0;
		while (busy !== 1'b0 && t < 300) begin
			@(negedge clk);
			t++;
		end
		repeat (4) @(negedge clk);
		chk("busy", 16'h0000, {15'h0000, busy});
		chk("frames received", 16'h0002, 16'(n_rxv - r0));
		chk("select drive enable", 16'h0000, {12'h000, oe_b});
		if (dchk) begin
			chk("slave data", b & m, got & m);
			chk("rx data", reply & m, rx & m);
		end
		chk("select edges", ee, 16'(n_edge - e0));
		$display("test done variant %0d len %0d", cfg.variant, cfg.frame_len);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		cfg.block_mode = SFM_BLOCK_MODE_SERIAL;
		cfg.master = 1'b1;
		cfg.frame_len = SFM_LEN_RESET;
		cfg.oversample_setting = SFM_OVS_RESET;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		link_en = 1'b0;
		repeat (3) @(negedge clk);
		for (int md = 0; md < 8; md++) begin
			{cfg.lsb_first, cfg.polarity, cfg.phase} = md[2:0];
			run(16'ha5c3, 16'h3c96, 16'h0001, 1'b1);
		end
		cfg.separated = 1'b1;
		cfg.frame_len = SFM_LEN_MIN;
		run(16'h0009, 16'h0006, 16'h0002, 1'b1);
		cfg.separated = 1'b0;
		cfg.frame_len = SFM_LEN_MAX;
		run(16'h8001, 16'h7ffe, 16'h0001, 1'b1);
		// Polarity 1, phase 0 configured: half duplex must still run mode 0
		cfg.variant = SFM_VARIANT_HALF;
		cfg.phase = 1'b0;
		run(16'h1234, 16'hedcb, 16'h0001, 1'b1);
		cfg.variant = SFM_VARIANT_PULSE;
		for (int ld = 0; ld < 2; ld++) begin
			cfg.lead = ld[0];
			run(16'h00f0, 16'h000f, 16'h0002, 1'b1);
		end
		cfg.master = 1'b0;
		link_en = 1'b1;
		valid = 1'b1;
		sel_in = 4'he;
		repeat (20) @(negedge clk);
		chk("ready refused", 16'h0000, {15'h0000, ready});
		chk("select seen", 16'h0001, {15'h0000, seen});
		chk("select drive enable", 16'h000f, {12'h000, oe_b});
		$display("test done slave operation");
		valid = 1'b0;
		link_en = 1'b0;
		end_sim();
	end
endmodule // sfm_master_tb_top
